// ---- hw/slps_core.sv ----
// system integration: status registers, break handling, wait/stop sequencing
`timescale 1ns/1ns
// How it works
// - register A shows pending flags six..one in bits 7..2; low bits zero.
// - register B shows pending flags fourteen..seven across all eight bits.
// - register C shows flags sixteen and fifteen in bits 1..0; rest zero.
// - a pending flag is one exactly while its source requests.
// - any reset outranks every interrupt and is never arbitrated.
// - a break request forces the next vector fetch to the software vector.
// - during break, flag clearing is blocked unless break clear enable is set.
// - a flag cleared during break stays cleared afterwards.
// - two-step clears stay blocked in break; second step works after break.
// - wait or stop clears the interrupt mask and stops processor clocks.
// - wait stops processor clocks, peripherals run, enabled interrupts wake.
// - after an interrupt wake from wait, stacking starts one cycle later; a break wake does not stack.
// - with watchdog disable clear, the watchdog runs through wait.
// - stop holds counter reset, clocks off, generator off unless kept running.
// - interrupt stop recovery lasts 4096 ticks, or 32 when short is selected.
// - stop exit by reset always uses the 4096-tick recovery.
// - stacking and clocks wait until stop recovery has elapsed.
// - counter held from stop until recovery, then times the recovery.
// - the wake flag reads one when a break ended wait.
// - reading the reset source register clears all its flags.
// - power-on sets only its flag; other sources add their own flag.
// - separate flags for pin, watchdog, opcode, address, monitor, low voltage.
module slps_core #(
  parameter int unsigned REC_LONG = slps_pkg::REC_LONG_CYC, // long recovery ticks
  parameter int unsigned REC_SHORT = slps_pkg::REC_SHORT_CYC // short recovery ticks
) (
  input wire logic aclk, // clock, 100 MHz
  input wire logic aresetn, // power-on reset, sync, active low
  input wire logic ce, // clock enable, freezes all state except the recovery counter, which still clears while hold is high
  input wire logic [slps_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [slps_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic [15:0] irq_req, // source requests, bit 0 is source one
  input wire logic irq_wake, // an enabled, active module interrupts
  input wire slps_pkg::slps_rst_src_t rst_src, // internal reset events
  input wire logic rst_pin_n, // external reset pin, asynchronous
  input wire logic brk_req, // break module output
  input wire logic brk_done, // processor leaves break state
  input wire logic wait_exec, // wait instruction executed
  input wire logic stop_exec, // stop instruction executed
  input wire logic xclk_tick, // one crystal-derived clock cycle
  output logic imask_clr, // clear processor interrupt mask
  output logic cpu_clk_en, // processor clocks run
  output logic periph_clk_en, // peripheral clocks run
  output logic clkgen_en, // clock generator outputs enabled
  output logic sys_cnt_hold, // system counter held in reset
  output logic stack_start, // begin interrupt stacking
  output slps_pkg::slps_vec_t vec_sel, // vector for the next fetch
  output logic clear_allow, // peripheral flag clearing allowed
  output logic brk_active, // break state
  output logic wdog_run // watchdog enabled
);
  slps_pkg::slps_lp_t state_ff;
  slps_pkg::slps_lp_t nxt_state;
  logic [7:0] rst_flags_ff;
  logic [7:0] cfg_ff;
  logic break_clear_enable_ff;
  logic wake_ff;
  logic rec_long_ff;
  logic pin_lvl;
  logic pin_prev_ff;
  logic pin_fall;
  logic any_rst;
  logic rec_done;
  logic [slps_pkg::REC_W-1:0] rec_limit;
  logic aw_have_ff;
  logic w_have_ff;
  logic [15:0] aw_idx_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic wr_go;
  logic rd_go;
  logic [15:0] ar_idx;
  logic [7:0] rd_val;
  logic rd_hit;
  logic rd_rst_src;

  slps_sync3 #(.RST_VAL(1'b1)) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .din(rst_pin_n),
    .dout(pin_lvl)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_prev_ff <= 1'b1;
    else if (ce)
      pin_prev_ff <= pin_lvl;
  end

  assign pin_fall = pin_prev_ff && !pin_lvl;
  assign any_rst = pin_fall || (|rst_src);

  // ---- register bus ----
  // address, data and read readies drop while frozen; a B or R handshake can still complete while frozen and is ignored
  assign awready = !aw_have_ff && !bvalid && ce;
  assign wready = !w_have_ff && !bvalid && ce;
  assign wr_go = aw_have_ff && w_have_ff && !bvalid;
  assign arready = !rvalid && ce;
  assign rd_go = arvalid && arready;
  assign ar_idx = araddr[17:2];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      aw_idx_ff <= 16'h0000;
      wd_ff <= 32'h0000_0000;
      ws_ff <= 4'h0;
      bvalid <= 1'b0;
      bresp <= slps_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_have_ff <= 1'b1;
        aw_idx_ff <= awaddr[17:2];
      end
      if (wvalid && wready)
      begin
        w_have_ff <= 1'b1;
        wd_ff <= wdata;
        ws_ff <= wstrb;
      end
      if (wr_go)
      begin
        aw_have_ff <= 1'b0;
        w_have_ff <= 1'b0;
        bvalid <= 1'b1;
        case (aw_idx_ff)
          slps_pkg::IDX_BRK_STAT, slps_pkg::IDX_RST_SRC, slps_pkg::IDX_BRK_CTL,
          slps_pkg::IDX_IRQ_A, slps_pkg::IDX_IRQ_B, slps_pkg::IDX_IRQ_C,
          slps_pkg::IDX_CFG: bresp <= slps_pkg::RESP_OKAY;
          default: bresp <= slps_pkg::RESP_DECERR;
        endcase
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (ar_idx)
      slps_pkg::IDX_BRK_STAT: rd_val[slps_pkg::BIT_WAKE] = wake_ff;
      slps_pkg::IDX_RST_SRC: rd_val = rst_flags_ff;
      slps_pkg::IDX_BRK_CTL: rd_val[slps_pkg::BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_ff;
      slps_pkg::IDX_IRQ_A: rd_val = {irq_req[5:0], 2'b00};
      slps_pkg::IDX_IRQ_B: rd_val = irq_req[13:6];
      slps_pkg::IDX_IRQ_C: rd_val = {6'b00_0000, irq_req[15:14]};
      slps_pkg::IDX_CFG: rd_val = cfg_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  assign rd_rst_src = rd_go && (ar_idx == slps_pkg::IDX_RST_SRC);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= slps_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rdata <= {24'h00_0000, rd_val};
        rresp <= rd_hit ? slps_pkg::RESP_OKAY : slps_pkg::RESP_DECERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

  // ---- software-written control ----
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_ff <= slps_pkg::CFG_RST_VAL;
      break_clear_enable_ff <= 1'b0;
    end
    else if (ce && wr_go && ws_ff[0])
    begin
      if (aw_idx_ff == slps_pkg::IDX_CFG)
        cfg_ff <= {5'b0_0000, wd_ff[2:0]};
      if (aw_idx_ff == slps_pkg::IDX_BRK_CTL)
        break_clear_enable_ff <= wd_ff[slps_pkg::BIT_BREAK_CLEAR_ENABLE];
    end
  end

  // power-on leaves only its own flag; later sources accumulate, set beats read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rst_flags_ff <= slps_pkg::RST_SRC_POR_VAL;
    else if (ce)
      rst_flags_ff <= (rd_rst_src ? 8'h00 : rst_flags_ff)
        | {1'b0, pin_fall, rst_src.wdog, rst_src.illegal_opcode_reset_flag, rst_src.illegal_address_reset_flag,
           rst_src.forced_monitor_reset_flag, rst_src.low_voltage_reset_flag, 1'b0};
  end

  // ---- break ----
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      brk_active <= 1'b0;
    else if (ce)
    begin
      if (any_rst)
        brk_active <= 1'b0;
      else if (brk_req)
        brk_active <= 1'b1;
      else if (brk_done)
        brk_active <= 1'b0;
    end
  end

  // peripherals gate both steps of a clear on this, so a first step taken
  // before break cannot complete inside it unless break clear enable is set; what was cleared stays cleared
  assign clear_allow = !brk_active || break_clear_enable_ff;

  // wake flag: set by a break ending wait, software clears by writing zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake_ff <= 1'b0;
    else if (ce)
    begin
      if (state_ff == slps_pkg::LP_WAIT && brk_req && !any_rst)
        wake_ff <= 1'b1;
      else if (wr_go && ws_ff[0] && aw_idx_ff == slps_pkg::IDX_BRK_STAT
               && !wd_ff[slps_pkg::BIT_WAKE])
        wake_ff <= 1'b0;
    end
  end

  // reset first, then break, then maskable interrupts
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      vec_sel <= slps_pkg::VEC_RESET;
    else if (ce)
    begin
      if (any_rst)
        vec_sel <= slps_pkg::VEC_RESET;
      else if (brk_req)
        vec_sel <= slps_pkg::VEC_SWI;
      else if (|irq_req)
        vec_sel <= slps_pkg::VEC_IRQ;
      else
        vec_sel <= slps_pkg::VEC_NONE;
    end
  end

  // ---- low-power sequencing ----
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      slps_pkg::LP_RUN:
        if (any_rst)
          nxt_state = slps_pkg::LP_RUN;
        else if (stop_exec)
          nxt_state = slps_pkg::LP_STOP;
        else if (wait_exec)
          nxt_state = slps_pkg::LP_WAIT;
      slps_pkg::LP_WAIT:
        if (any_rst || irq_wake || brk_req)
          nxt_state = slps_pkg::LP_RUN;
      slps_pkg::LP_STOP:
        if (any_rst || irq_wake)
          nxt_state = slps_pkg::LP_RECOV;
      slps_pkg::LP_RECOV:
        if (rec_done)
          nxt_state = slps_pkg::LP_RUN;
      default: nxt_state = slps_pkg::LP_RUN;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= slps_pkg::LP_RUN;
    else if (ce)
      state_ff <= nxt_state;
  end

  // a reset during stop or recovery forces the long interval
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rec_long_ff <= 1'b0;
    else if (ce)
    begin
      if (state_ff == slps_pkg::LP_STOP && nxt_state == slps_pkg::LP_RECOV)
        rec_long_ff <= any_rst || !cfg_ff[slps_pkg::BIT_SHORT_REC];
      else if (state_ff == slps_pkg::LP_RECOV && any_rst)
        rec_long_ff <= 1'b1;
    end
  end

  assign rec_limit = rec_long_ff ? slps_pkg::REC_W'(REC_LONG)
                                 : slps_pkg::REC_W'(REC_SHORT);

  slps_rec_cnt #(.W(slps_pkg::REC_W)) u_rec (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .hold(sys_cnt_hold),
    .tick(xclk_tick),
    .limit(rec_limit),
    .done(rec_done)
  );

  // clock enables follow the next state so they match state_ff
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      clkgen_en <= 1'b1;
      sys_cnt_hold <= 1'b1;
      imask_clr <= 1'b0;
      stack_start <= 1'b0;
    end
    else if (ce)
    begin
      cpu_clk_en <= nxt_state == slps_pkg::LP_RUN;
      periph_clk_en <= nxt_state == slps_pkg::LP_RUN
                    || nxt_state == slps_pkg::LP_WAIT;
      clkgen_en <= nxt_state != slps_pkg::LP_STOP
                || cfg_ff[slps_pkg::BIT_OSC_KEEP];
      sys_cnt_hold <= nxt_state != slps_pkg::LP_RECOV;
      imask_clr <= state_ff == slps_pkg::LP_RUN && !any_rst
                && (stop_exec || wait_exec);
      stack_start <= !any_rst && ((state_ff == slps_pkg::LP_WAIT && irq_wake)
                  || (state_ff == slps_pkg::LP_RECOV && rec_done
                      && !rec_long_ff))
                  || (state_ff == slps_pkg::LP_RECOV && rec_done && rec_long_ff
                      && !any_rst && irq_wake);
    end
  end

  // watchdog keeps running in wait unless disabled by configuration
  assign wdog_run = !cfg_ff[slps_pkg::BIT_WDOG_DIS];

  // ---- checks ----
  sequence s_wait_wake;
    state_ff == slps_pkg::LP_WAIT && irq_wake && !any_rst && ce;
  endsequence

  a_wait_stack_next: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wait_wake |=> stack_start && cpu_clk_en)
    else $error("stacking not one cycle after wait wake");
  a_rst_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_rst_src && !any_rst |=> rst_flags_ff == 8'h00 && rdata[7:0] == $past(rst_flags_ff))
    else $error("reset source register not cleared by read");
  a_por_only_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    !$past(aresetn) |-> rst_flags_ff == slps_pkg::RST_SRC_POR_VAL)
    else $error("power-on did not leave only its flag");
  a_irq_a_layout: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && ar_idx == slps_pkg::IDX_IRQ_A |=> rdata == {24'h0, $past(irq_req[5:0]), 2'b00})
    else $error("pending register A layout wrong");
  a_irq_c_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && ar_idx == slps_pkg::IDX_IRQ_C |=> rdata[7:2] == 6'h00
      && rdata[1:0] == $past(irq_req[15:14]))
    else $error("pending register C layout wrong");
  a_reset_vector_first: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && any_rst |=> vec_sel == slps_pkg::VEC_RESET)
    else $error("reset did not take the vector");
  a_break_swi_vec: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && brk_req && !any_rst |=> vec_sel == slps_pkg::VEC_SWI && brk_active)
    else $error("break did not force software vector");
  a_break_protect: assert property (@(posedge aclk) disable iff (!aresetn)
    brk_active && !break_clear_enable_ff |-> !clear_allow)
    else $error("flag clearing allowed in protected break");
  a_lowpower_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && state_ff == slps_pkg::LP_RUN && !any_rst && (wait_exec || stop_exec)
    |=> imask_clr && !cpu_clk_en)
    else $error("low-power entry did not clear mask and stop clocks");
  a_stop_clocks_off: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == slps_pkg::LP_STOP |-> !cpu_clk_en && !periph_clk_en && sys_cnt_hold
      && (clkgen_en == cfg_ff[slps_pkg::BIT_OSC_KEEP]))
    else $error("stop state outputs wrong");
  a_recov_no_stack: assert property (@(posedge aclk) disable iff (!aresetn)
    state_ff == slps_pkg::LP_RECOV && !rec_done |=> !stack_start && !cpu_clk_en)
    else $error("stacking before recovery elapsed");
endmodule

// ---- hw/slps_pkg.sv ----
// shared constants and types of the low-power and status block
package slps_pkg;
  localparam int unsigned ADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_BRK_STAT = 16'hfe00;
  localparam logic [15:0] IDX_RST_SRC = 16'hfe01;
  localparam logic [15:0] IDX_BRK_CTL = 16'hfe03;
  localparam logic [15:0] IDX_IRQ_A = 16'hfe04;
  localparam logic [15:0] IDX_IRQ_B = 16'hfe05;
  localparam logic [15:0] IDX_IRQ_C = 16'hfe06;
  localparam logic [15:0] IDX_CFG = 16'hfe08;
  // field positions
  localparam int unsigned BIT_WAKE = 1;
  localparam int unsigned BIT_BREAK_CLEAR_ENABLE = 7;
  localparam int unsigned BIT_SHORT_REC = 0;
  localparam int unsigned BIT_OSC_KEEP = 1;
  localparam int unsigned BIT_WDOG_DIS = 2;
  localparam int unsigned BIT_POR = 7;
  // reset values
  localparam logic [7:0] RST_SRC_POR_VAL = 8'h80;
  localparam logic [7:0] CFG_RST_VAL = 8'h00;
  localparam logic [7:0] IRQ_A_RST_VAL = 8'h00;
  // stop recovery, in crystal-derived clock cycles
  localparam int unsigned REC_LONG_CYC = 4096;
  localparam int unsigned REC_SHORT_CYC = 32;
  localparam int unsigned REC_W = 13;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  // internal reset events, one-cycle pulses from reset logic on aclk
  typedef struct packed {
    logic wdog;
    logic illegal_opcode_reset_flag;
    logic illegal_address_reset_flag;
    logic forced_monitor_reset_flag;
    logic low_voltage_reset_flag;
  } slps_rst_src_t;

  typedef enum logic [1:0] {
    LP_RUN = 2'b00,
    LP_STOP = 2'b01,
    LP_RECOV = 2'b11,
    LP_WAIT = 2'b10
  } slps_lp_t;

  typedef enum logic [1:0] {
    VEC_NONE = 2'b00,
    VEC_RESET = 2'b01,
    VEC_SWI = 2'b10,
    VEC_IRQ = 2'b11
  } slps_vec_t;
endpackage

// ---- hw/slps_sync3.sv ----
// three-stage synchroniser; output moves only when stages two and three agree
`timescale 1ns/1ns
module slps_sync3 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic din, // asynchronous input
  output logic dout // filtered level
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
      dout <= RST_VAL;
    end
    else if (ce)
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        dout <= s3_ff;
    end
  end
endmodule

// ---- hw/slps_rec_cnt.sv ----
// recovery counter on crystal-derived ticks; held at zero while hold is high
`timescale 1ns/1ns
module slps_rec_cnt #(
  parameter int unsigned W = slps_pkg::REC_W
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, active low
  input wire logic ce, // clock enable
  input wire logic hold, // keep counter in reset
  input wire logic tick, // one crystal-derived cycle
  input wire logic [W-1:0] limit, // cycles to count
  output logic done // high on the last tick and on every later tick until hold
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || hold)
      cnt_ff <= '0;
    else if (ce && tick && !done)
      cnt_ff <= cnt_ff + W'(1);
  end

  assign done = !hold && tick && (cnt_ff == limit - W'(1));
endmodule

// ---- tb/slps_tb.sv ----
// self-checking bench for the low-power and status block
`timescale 1ns/1ns
module testbench;
  localparam int RL = 64;
  localparam int RS = 8;
  logic aclk, aresetn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq_wake, rst_pin_n, brk_req, brk_done;
  logic wait_exec, stop_exec, imask_clr, cpu_clk_en, periph_clk_en;
  logic xclk_tick = 1'b0;
  logic clkgen_en, sys_cnt_hold, stack_start, clear_allow, brk_active, wdog_run;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [15:0] irq_req;
  logic [7:0] d;
  slps_pkg::slps_rst_src_t rst_src;
  slps_pkg::slps_vec_t vec_sel;
  int n_mismatch, check_count, ni, ns, k;

  slps_core #(.REC_LONG(RL), .REC_SHORT(RS)) dut (.aclk, .aresetn, .ce, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq_req,
    .irq_wake, .rst_src, .rst_pin_n, .brk_req, .brk_done, .wait_exec, .stop_exec,
    .xclk_tick, .imask_clr, .cpu_clk_en, .periph_clk_en, .clkgen_en, .sys_cnt_hold,
    .stack_start, .vec_sel, .clear_allow, .brk_active, .wdog_run);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // crystal ticks at half the bus rate, so recovery takes twice its tick count
  always @(posedge aclk) xclk_tick <= ~xclk_tick;
  always @(posedge aclk) if (imask_clr === 1'b1) ni++;
  always @(posedge aclk) if (stack_start === 1'b1) ns++;

  task end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tout();
    n_mismatch++;
    $display("[FAIL] wait limit expired");
    end_sim();
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] v);
    int i;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (i == 100) tout();
  endtask

  task rd(input logic [15:0] idx);
    int i;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 100; i++)
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
    if (i == 100) tout();
  endtask

  task rchk(input string nm, input logic [15:0] idx, input logic [7:0] exp);
    rd(idx);
    chk(nm, d, exp);
    chk("rresp", r, slps_pkg::RESP_OKAY);
  endtask

  // 0 wake, 1 break, 2 break end, 3 wait, 4 stop, else reset event v
  task pulse(input int w, input logic [4:0] v);
    @(posedge aclk);
    case (w)
      0: irq_wake <= 1'b1;
      1: brk_req <= 1'b1;
      2: brk_done <= 1'b1;
      3: wait_exec <= 1'b1;
      4: stop_exec <= 1'b1;
      default: rst_src <= slps_pkg::slps_rst_src_t'(v);
    endcase
    @(posedge aclk);
    {irq_wake, brk_req, brk_done, wait_exec, stop_exec} <= 5'h00;
    rst_src <= slps_pkg::slps_rst_src_t'(5'h00);
    repeat (3) @(posedge aclk);
  endtask

  task rec(input int lim);
    int n;
    for (n = 0; n < 1000 && cpu_clk_en !== 1'b1; n++)
    begin
      @(posedge aclk);
      if (n == 4) chk("cnt_hold", sys_cnt_hold, 1'b0);
      if (n == 4) chk("periph", periph_clk_en, 1'b0);
    end
    if (n == 1000) tout();
    chk("rec_len", n >= 2 * lim - 8 && n <= 2 * lim + 4, 1'b1);
  endtask

  task do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, irq_wake, brk_req, brk_done} = 8'h00;
    {wait_exec, stop_exec} = 2'b00;
    {aresetn, ce, rst_pin_n} = 3'b011;
    awaddr = 18'h00000;
    araddr = 18'h00000;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    irq_req = 16'h0000;
    rst_src = slps_pkg::slps_rst_src_t'(5'h00);
    do_reset();
    rchk("rst_src", slps_pkg::IDX_RST_SRC, slps_pkg::RST_SRC_POR_VAL);
    rchk("rst_src", slps_pkg::IDX_RST_SRC, 8'h00);
    rchk("irq_a", slps_pkg::IDX_IRQ_A, slps_pkg::IRQ_A_RST_VAL);
    rchk("brk_ctl", slps_pkg::IDX_BRK_CTL, 8'h00);
    rchk("cfg", slps_pkg::IDX_CFG, slps_pkg::CFG_RST_VAL);
    rd(16'hfe02);
    chk("unmapped", r, slps_pkg::RESP_DECERR);
    wr(16'hfe02, 8'hff);
    chk("unmapped_wr", r, slps_pkg::RESP_DECERR);
    $display("test reset_values done");
    for (k = 0; k < 16; k++)
    begin
      irq_req <= 16'h0001 << k;
      rchk("irq_a", slps_pkg::IDX_IRQ_A, k < 6 ? 8'h04 << k : 8'h00);
      rchk("irq_b", slps_pkg::IDX_IRQ_B, (k > 5 && k < 14) ? 8'h01 << (k - 6) : 8'h00);
      rchk("irq_c", slps_pkg::IDX_IRQ_C, k > 13 ? 8'h01 << (k - 14) : 8'h00);
    end
    irq_req <= 16'hffff;
    wr(slps_pkg::IDX_IRQ_A, 8'h00);
    chk("ro_write", r, slps_pkg::RESP_OKAY);
    chk("vec_irq", vec_sel, slps_pkg::VEC_IRQ);
    rchk("irq_a", slps_pkg::IDX_IRQ_A, 8'hfc);
    rchk("irq_c", slps_pkg::IDX_IRQ_C, 8'h03);
    irq_req <= 16'h0000;
    rchk("irq_b", slps_pkg::IDX_IRQ_B, 8'h00);
    $display("test irq_status done");
    for (k = 0; k < 5; k++)
    begin
      pulse(5, 5'h01 << k);
      rchk("rst_one", slps_pkg::IDX_RST_SRC, 8'h02 << k);
    end
    pulse(5, 5'h10);
    pulse(5, 5'h01);
    rchk("rst_both", slps_pkg::IDX_RST_SRC, 8'h22);
    rst_pin_n <= 1'b0;
    repeat (8) @(posedge aclk);
    rst_pin_n <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk("rst_pin", slps_pkg::IDX_RST_SRC, 8'h40);
    pulse(5, 5'h1f);
    do_reset();
    rchk("rst_por", slps_pkg::IDX_RST_SRC, slps_pkg::RST_SRC_POR_VAL);
    $display("test reset_source done");
    // the vector select follows the request by one cycle and stands for one
    @(posedge aclk);
    brk_req <= 1'b1;
    @(posedge aclk);
    brk_req <= 1'b0;
    @(posedge aclk);
    chk("vec", vec_sel, slps_pkg::VEC_SWI);
    chk("brk", brk_active, 1'b1);
    chk("clr", clear_allow, 1'b0);
    wr(slps_pkg::IDX_BRK_CTL, 8'h80);
    rchk("brk_ctl", slps_pkg::IDX_BRK_CTL, 8'h80);
    chk("clr", clear_allow, 1'b1);
    wr(slps_pkg::IDX_BRK_CTL, 8'h00);
    chk("clr", clear_allow, 1'b0);
    pulse(2, 5'h00);
    chk("brk", brk_active, 1'b0);
    chk("clr", clear_allow, 1'b1);
    @(posedge aclk);
    brk_req <= 1'b1;
    rst_src <= slps_pkg::slps_rst_src_t'(5'h10);
    @(posedge aclk);
    brk_req <= 1'b0;
    rst_src <= slps_pkg::slps_rst_src_t'(5'h00);
    @(posedge aclk);
    chk("vec_rst", vec_sel, slps_pkg::VEC_RESET);
    chk("brk_rst", brk_active, 1'b0);
    $display("test break done");
    ni = 0;
    ns = 0;
    pulse(3, 5'h00);
    chk("imask", ni, 1);
    chk("cpu_wait", cpu_clk_en, 1'b0);
    chk("per_wait", periph_clk_en, 1'b1);
    chk("wdog", wdog_run, 1'b1);
    pulse(0, 5'h00);
    chk("stack", ns, 1);
    chk("cpu_run", cpu_clk_en, 1'b1);
    pulse(3, 5'h00);
    pulse(1, 5'h00);
    chk("stack_brk", ns, 1);
    rchk("wake_flag", slps_pkg::IDX_BRK_STAT, 8'h02);
    pulse(2, 5'h00);
    wr(slps_pkg::IDX_BRK_STAT, 8'h00);
    rchk("wake_flag", slps_pkg::IDX_BRK_STAT, 8'h00);
    wr(slps_pkg::IDX_CFG, 8'h04);
    chk("wdog_off", wdog_run, 1'b0);
    $display("test wait done");
    wr(slps_pkg::IDX_CFG, 8'h01);
    ni = 0;
    ns = 0;
    pulse(4, 5'h00);
    chk("imask", ni, 1);
    chk("hold", sys_cnt_hold, 1'b1);
    chk("cpu_stop", cpu_clk_en, 1'b0);
    chk("per_stop", periph_clk_en, 1'b0);
    chk("gen_off", clkgen_en, 1'b0);
    pulse(0, 5'h00);
    rec(RS);
    @(posedge aclk);
    chk("stack", ns, 1);
    wr(slps_pkg::IDX_CFG, 8'h03);
    pulse(4, 5'h00);
    chk("gen_keep", clkgen_en, 1'b1);
    pulse(5, 5'h01);
    rec(RL);
    ce <= 1'b0;
    pulse(4, 5'h00);
    chk("ce_freeze", cpu_clk_en, 1'b1);
    ce <= 1'b1;
    $display("test stop done");
    end_sim();
  end
endmodule
